// ---- rtl/uart_bst_pkg.sv ----
// Package of register map, field positions, reset values and timing counts for the channel
// Function
// - Block DMA transmit waits for free-space trigger
// - Receive trigger level from fifo control bits 7:6
// - Sleep needs enhanced enable and sleep enable
// - Sleep needs idle line, empty transmit, no interrupts
// - No sleep while receive FIFO holds data
// - Asleep stops the baud generator run enable
// - Wake on line edge, modem change, transmit write
// - Timeout after four words plus twelve bits idle
// - Line control bit 6 forces transmit low
// - Divisor spans one to 65535
// - Baud tick runs at sixteen times bit rate
// - Divide-by-four prescaler by pin or modem bit 7
// - Low byte and high byte form divisor
// - Zero divisor produces no baud tick
// - One baud tick serves transmitter and receiver
// - Reset loads modem bit 7 as inverted pin
// - Divisor and scratch survive reset
// - Timeout raises code 001100, cleared by receive read
package uart_bst_pkg;
    // ************************************************************
    // Register indices
    // ************************************************************
    localparam logic [3:0] ADDR_RX_TX = 4'h0;
    localparam logic [3:0] ADDR_INT_ENABLE = 4'h1;
    localparam logic [3:0] ADDR_FIFO_CTRL = 4'h2;
    localparam logic [3:0] ADDR_LINE_CTRL = 4'h3;
    localparam logic [3:0] ADDR_MODEM_CTRL = 4'h4;
    localparam logic [3:0] ADDR_SCRATCH = 4'h7;
    localparam logic [3:0] ADDR_DIV_LOW = 4'h8;
    localparam logic [3:0] ADDR_DIV_HIGH = 4'h9;
    localparam logic [3:0] ADDR_ENH_FEAT = 4'ha;
    localparam logic [3:0] ADDR_STATUS = 4'hb;
    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int TX_TRIG_LO = 4;
    localparam int RX_TRIG_LO = 6;
    localparam int DMA_MODE_BIT = 3;
    localparam int SLEEP_EN_BIT = 4;
    localparam int ENH_EN_BIT = 4;
    localparam int BREAK_BIT = 6;
    localparam int PRESCALE_BIT = 7;
    // ************************************************************
    // Reset values, codes and timing
    // ************************************************************
    localparam logic [7:0] LINE_CTRL_RESET = 8'h1d;
    localparam logic [5:0] IID_TIMEOUT = 6'h0c;
    localparam logic [5:0] IID_NONE = 6'h01;
    localparam int PRESCALE_DIV = 4;
    localparam int OVERSAMPLE = 16;
    localparam int TIMEOUT_WORDS = 4;
    localparam int TIMEOUT_EXTRA_BITS = 12;
    localparam logic [7:0] RESET_DIV_LOW = 8'h00;
    localparam logic [7:0] RESET_DIV_HIGH = 8'h00;
endpackage

// ---- rtl/baud_gen.sv ----
// Prescaler and 16-bit divisor producing the sixteen-times sample tick
`timescale 1ns/1ns
module baud_gen
    import uart_bst_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_run,
    input wire logic i_prescale,
    input wire logic [DIV_W-1:0] i_divisor,
    input wire logic i_reload,
    output logic o_tick
);
    typedef struct packed {
        logic [1:0] pre;
        logic [DIV_W-1:0] cnt;
        logic tick;
    } bg_state_t;
    bg_state_t s_q, s_d;
    logic pre_en;

    // Prescale strobe: every fourth clock when selected, else every clock
    always_comb begin
        pre_en = i_prescale ? (s_q.pre == 2'(PRESCALE_DIV - 1)) : 1'b1;
    end

    // Counter reloads on a divisor write so a new rate starts cleanly
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        if (i_run) begin
            s_d.pre = i_prescale ? s_q.pre + 2'd1 : 2'd0;
        end
        if (i_reload || i_divisor == '0) begin
            s_d.cnt = '0;
        end else if (i_run && pre_en) begin
            if (s_q.cnt >= i_divisor - 1'b1) begin
                s_d.cnt = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign o_tick = s_q.tick & i_ce;

    // A frozen cycle keeps the old tick, so only enabled cycles are judged
    chk_zero_no_tick: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_ce && i_divisor == '0) |=> !s_q.tick) else $error("tick with zero divisor");
endmodule // baud_gen

// ---- rtl/rx_timeout.sv ----
// Receive idle timer flagging stale receive FIFO data
`timescale 1ns/1ns
module rx_timeout
    import uart_bst_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic i_tick,
    input wire logic i_rx_high,
    input wire logic i_rx_nonempty,
    input wire logic [3:0] i_word_len,
    input wire logic i_clear,
    output logic o_timeout
);
    typedef struct packed {
        logic [11:0] cnt;
        logic flag;
    } to_state_t;
    to_state_t s_q, s_d;
    logic [11:0] limit;

    // Limit in sample ticks: (4*len+12) bits times sixteen
    always_comb begin
        limit = 12'((TIMEOUT_WORDS * i_word_len + TIMEOUT_EXTRA_BITS) * OVERSAMPLE);
    end

    // A read clear loses to a timeout reached the same cycle
    always_comb begin
        s_d = s_q;
        if (!i_rx_high || !i_rx_nonempty) begin
            s_d.cnt = '0;
        end else if (i_tick && s_q.cnt != limit) begin
            s_d.cnt = s_q.cnt + 12'd1;
        end
        if (i_clear) begin
            s_d.flag = 1'b0;
            s_d.cnt = '0;
        end
        if (i_rx_high && i_rx_nonempty && s_q.cnt == limit && !s_q.flag) begin
            s_d.flag = 1'b1;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_q <= '0;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    assign o_timeout = s_q.flag;

    chk_timeout_needs_data: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(s_q.flag) |-> $past(i_rx_nonempty)) else $error("timeout without data");
endmodule // rx_timeout

// ---- rtl/uart_baud_sleep_timeout.sv ----
// Channel top: registers, sleep control, break, trigger levels, baud and timeout
//
// The address-and-strobe port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
module uart_baud_sleep_timeout
    import uart_bst_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic i_ce,
    input wire logic [3:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    input wire logic i_prescale_select_pin,
    input wire logic i_rx,
    input wire logic [3:0] i_modem_in,
    input wire logic i_tx_serial,
    input wire logic i_tx_fifo_empty,
    input wire logic i_tsr_empty,
    input wire logic [6:0] i_tx_free,
    input wire logic i_rx_nonempty,
    input wire logic i_other_irq,
    output logic o_tx,
    output logic o_baud_tick,
    output logic o_tx_go,
    output logic [1:0] o_tx_trig,
    output logic [1:0] o_rx_trig,
    output logic o_asleep,
    output logic o_timeout,
    output logic [5:0] o_iid,
    output logic o_rx_read
);
    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [1:0] rx_sync;
        logic [1:0] pin_sync;
        logic [7:0] modem_sync_a;
        logic [3:0] modem_prev;
        logic rx_prev;
        logic pin_caught;
        logic [7:0] interrupt_enable_reg;
        logic [7:0] fifo_control_reg;
        logic [7:0] line_control_reg;
        logic [7:0] modem_control_reg;
        logic [7:0] enhanced_feature_reg;
        logic asleep;
        logic tx_q;
        logic [7:0] rdata;
    } top_state_t;
    // Registers kept through reset live apart from the reset state
    typedef struct packed {
        logic [7:0] div_low;
        logic [7:0] divisor_high_byte;
        logic [7:0] scratch_reg;
    } keep_state_t;

    top_state_t s_q, s_d;
    keep_state_t k_q, k_d;
    logic tick;
    logic timeout;
    logic rx_idle;
    logic wake;
    logic can_sleep;
    logic run;
    logic div_wr;
    logic rx_read;
    logic [3:0] word_len;
    logic [6:0] tx_need;

    // Free-space trigger in bytes, from two code bits
    function automatic logic [6:0] trig_count(input logic [1:0] code);
        unique case (code)
            2'b00: trig_count = 7'd8;
            2'b01: trig_count = 7'd16;
            2'b10: trig_count = 7'd32;
            2'b11: trig_count = 7'd56;
        endcase
    endfunction

    // ************************************************************
    // Decodes
    // ************************************************************
    always_comb begin
        rx_idle = s_q.rx_sync[1];
        rx_read = i_rd && i_addr == ADDR_RX_TX;
        div_wr = i_wr && (i_addr == ADDR_DIV_LOW || i_addr == ADDR_DIV_HIGH);
        word_len = 4'd5 + {2'b00, s_q.line_control_reg[1:0]};
        tx_need = trig_count(s_q.fifo_control_reg[TX_TRIG_LO +: 2]);
        // Edges seen on synchronised copies only
        wake = (s_q.rx_sync[1] != s_q.rx_prev)
            || (s_q.modem_sync_a[7:4] != s_q.modem_prev)
            || (i_wr && i_addr == ADDR_RX_TX);
        can_sleep = s_q.enhanced_feature_reg[ENH_EN_BIT]
            && s_q.interrupt_enable_reg[SLEEP_EN_BIT]
            && rx_idle && i_tx_fifo_empty && i_tsr_empty
            && !i_other_irq
            && !i_rx_nonempty;
        run = !s_q.asleep;
    end

    // ************************************************************
    // Register file and sleep control
    // ************************************************************
    always_comb begin
        s_d = s_q;
        k_d = k_q;
        s_d.rx_sync = {s_q.rx_sync[0], i_rx};
        s_d.pin_sync = {s_q.pin_sync[0], i_prescale_select_pin};
        s_d.modem_sync_a = {s_q.modem_sync_a[3:0], i_modem_in};
        s_d.modem_prev = s_q.modem_sync_a[7:4];
        s_d.rx_prev = s_q.rx_sync[1];
        // Strap caught from the synchronised pin just after reset; needs two reset edges
        if (!s_q.pin_caught) begin
            s_d.pin_caught = 1'b1;
            s_d.modem_control_reg[PRESCALE_BIT] = ~s_q.pin_sync[1];
            s_d.enhanced_feature_reg[7] = ~s_q.pin_sync[1];
        end
        if (i_wr) begin
            unique case (i_addr)
                ADDR_INT_ENABLE: s_d.interrupt_enable_reg = i_wdata;
                ADDR_FIFO_CTRL: s_d.fifo_control_reg = i_wdata;
                ADDR_LINE_CTRL: s_d.line_control_reg = i_wdata;
                ADDR_MODEM_CTRL: s_d.modem_control_reg = i_wdata;
                ADDR_ENH_FEAT: s_d.enhanced_feature_reg = i_wdata;
                ADDR_SCRATCH: k_d.scratch_reg = i_wdata;
                // Host must clear sleep enable first; writes here also reload the baud counter
                ADDR_DIV_LOW: k_d.div_low = i_wdata;
                ADDR_DIV_HIGH: k_d.divisor_high_byte = i_wdata;
                default: ;
            endcase
        end
        // Wake has priority over entry so no event is lost
        if (s_q.asleep) begin
            if (wake || !can_sleep) begin
                s_d.asleep = 1'b0;
            end
        end else if (can_sleep && !wake) begin
            s_d.asleep = 1'b1;
        end
        s_d.tx_q = s_q.line_control_reg[BREAK_BIT] ? 1'b0 : i_tx_serial;
        s_d.rdata = 8'h00;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_INT_ENABLE: s_d.rdata = s_q.interrupt_enable_reg;
                ADDR_LINE_CTRL: s_d.rdata = s_q.line_control_reg;
                ADDR_MODEM_CTRL: s_d.rdata = s_q.modem_control_reg;
                ADDR_ENH_FEAT: s_d.rdata = s_q.enhanced_feature_reg;
                ADDR_SCRATCH: s_d.rdata = k_q.scratch_reg;
                ADDR_DIV_LOW: s_d.rdata = k_q.div_low;
                ADDR_DIV_HIGH: s_d.rdata = k_q.divisor_high_byte;
                ADDR_STATUS: s_d.rdata = {5'd0, timeout, s_q.asleep, tick};
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            s_q <= '0;
            // Pin synchronisers keep sampling so no stale strap or false edge follows reset
            s_q.pin_sync <= s_d.pin_sync;
            s_q.modem_sync_a <= s_d.modem_sync_a;
            s_q.modem_prev <= s_d.modem_prev;
            s_q.rx_sync <= 2'b11;
            s_q.rx_prev <= 1'b1;
            s_q.line_control_reg <= LINE_CTRL_RESET;
            s_q.tx_q <= 1'b1;
        end else if (i_ce) begin
            s_q <= s_d;
        end
    end

    // Not reset: contents survive hardware reset
    always_ff @(posedge i_sys_clk) begin
        if (i_ce) begin
            k_q <= k_d;
        end
    end

    // ************************************************************
    // Baud generator and timeout detector
    // ************************************************************
    baud_gen u_baud (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_run(run),
        .i_prescale(s_q.pin_sync[1] | s_q.modem_control_reg[PRESCALE_BIT]),
        .i_divisor({k_q.divisor_high_byte, k_q.div_low}),
        .i_reload(div_wr),
        .o_tick(tick)
    );

    rx_timeout u_timeout (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_ce(i_ce),
        .i_tick(tick),
        .i_rx_high(rx_idle),
        .i_rx_nonempty(i_rx_nonempty),
        .i_word_len(word_len),
        .i_clear(rx_read),
        .o_timeout(timeout)
    );

    // ************************************************************
    // Outputs
    // ************************************************************
    assign o_baud_tick = tick;
    assign o_tx = s_q.tx_q;
    assign o_tx_trig = s_q.fifo_control_reg[TX_TRIG_LO +: 2];
    assign o_rx_trig = s_q.fifo_control_reg[RX_TRIG_LO +: 2];
    // Block DMA holds transmit until enough free space; mode 0 always goes
    assign o_tx_go = !s_q.fifo_control_reg[DMA_MODE_BIT] || i_tx_free >= tx_need;
    assign o_asleep = s_q.asleep;
    assign o_timeout = timeout;
    assign o_iid = timeout ? IID_TIMEOUT : IID_NONE;
    assign o_rx_read = rx_read;
    assign o_rdata = s_q.rdata;

    chk_break_forces_low: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_ce && s_q.line_control_reg[BREAK_BIT]) |=> !o_tx) else $error("break not low");
    chk_sleep_needs_enable: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(s_q.asleep) |-> $past(s_q.interrupt_enable_reg[SLEEP_EN_BIT]
        && s_q.enhanced_feature_reg[ENH_EN_BIT])) else $error("sleep not enabled");
    chk_sleep_rx_empty: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(s_q.asleep) |-> $past(!i_rx_nonempty)) else $error("slept with rx data");
    chk_sleep_tx_empty: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(s_q.asleep) |-> $past(i_tx_fifo_empty && i_tsr_empty)) else $error("tx busy");
    chk_sleep_line_idle: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $rose(s_q.asleep) |-> $past(rx_idle && !i_other_irq)) else $error("slept while busy");
    chk_asleep_no_tick: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        s_q.asleep ##1 s_q.asleep |-> !tick) else $error("tick while asleep");
    chk_wake_on_write: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_ce && s_q.asleep && i_wr && i_addr == ADDR_RX_TX) |=> !s_q.asleep)
        else $error("no wake on write");
    chk_wake_on_modem: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (i_ce && s_q.asleep && s_q.modem_sync_a[7:4] != s_q.modem_prev) |=> !s_q.asleep)
        else $error("no wake on modem change");
    chk_timeout_iid: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        timeout |-> o_iid == 6'h0c) else $error("timeout code wrong");
    chk_dma_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s_q.fifo_control_reg[DMA_MODE_BIT] && i_tx_free < 7'd8) |-> !o_tx_go)
        else $error("dma went early");
    // The largest trigger is 56 spaces, so that much room always releases transmit
    chk_dma_release: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        (s_q.fifo_control_reg[DMA_MODE_BIT] && i_tx_free >= 7'd56) |-> o_tx_go)
        else $error("dma held with space");
endmodule // uart_baud_sleep_timeout

// ---- verif/remote_serial.sv ----
// Remote serial transceiver model driving the receive line
`timescale 1ns/1ns
module remote_serial #(
    parameter int BIT_CYCLES = 8
) (
    input wire logic i_sys_clk,
    input wire logic i_send,
    input wire logic [7:0] i_byte,
    output logic o_rx
);
    logic [9:0] frame_q = 10'h3ff;
    int bits_q = 0;
    int cnt_q = 0;
    // ************************************************************
    // Frame shifter
    // ************************************************************
    // Own bit timer: the far end keeps sending while our baud tick is stopped
    always @(posedge i_sys_clk) begin
        if (i_send && bits_q == 0) begin
            frame_q <= {1'b1, i_byte, 1'b0};
            bits_q <= 10;
            cnt_q <= BIT_CYCLES;
        end else if (bits_q != 0) begin
            if (cnt_q == 1) begin
                frame_q <= {1'b1, frame_q[9:1]};
                bits_q <= bits_q - 1;
                cnt_q <= BIT_CYCLES;
            end else begin
                cnt_q <= cnt_q - 1;
            end
        end
    end
    // Line rests at mark level outside frames
    assign o_rx = (bits_q == 0) ? 1'b1 : frame_q[0];
endmodule // remote_serial

// ---- verif/uart_baud_sleep_timeout_bench.sv ----
// Self-checking bench for baud, sleep, break, trigger and timeout logic
`timescale 1ns/1ns
module uart_baud_sleep_timeout_bench;
    import uart_bst_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic pin = 1'b0;
    logic tx_ser = 1'b1;
    logic tx_empty = 1'b1;
    logic tsr_empty = 1'b1;
    logic rx_ne = 1'b0;
    logic oirq = 1'b0;
    logic send = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [3:0] modem = 4'h0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic [7:0] v;
    logic [6:0] tx_free = 7'h00;
    logic rx, tx, tick, go, asleep, tout, rx_read;
    logic [1:0] ttrig, rtrig;
    logic [5:0] iid;
    int num_errors = 0;
    int num_checks = 0;
    int gap;
    int need [4] = '{8, 16, 32, 56};
    localparam int TO_TICKS = (TIMEOUT_WORDS * 5 + TIMEOUT_EXTRA_BITS) * OVERSAMPLE;

    always #2 sys_clk = ~sys_clk;

    uart_baud_sleep_timeout dut_u (.i_sys_clk(sys_clk), .i_rst(rst), .i_ce(ce), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_prescale_select_pin(pin),
        .i_rx(rx), .i_modem_in(modem), .i_tx_serial(tx_ser), .i_tx_fifo_empty(tx_empty),
        .i_tsr_empty(tsr_empty), .i_tx_free(tx_free), .i_rx_nonempty(rx_ne),
        .i_other_irq(oirq), .o_tx(tx), .o_baud_tick(tick), .o_tx_go(go), .o_tx_trig(ttrig),
        .o_rx_trig(rtrig), .o_asleep(asleep), .o_timeout(tout), .o_iid(iid),
        .o_rx_read(rx_read));
    remote_serial remote_u (.i_sys_clk(sys_clk), .i_send(send), .i_byte(8'ha5), .o_rx(rx));

    // ************************************************************
    // Shared tasks
    // ************************************************************
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge sys_clk);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic cycles(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    // Gap between two ticks; 2000 means the tick never came
    task automatic tick_gap();
        int n;
        n = 0;
        gap = 0;
        #1;
        while (tick !== 1'b1 && n < 2000) begin
            cycles(1);
            n++;
        end
        do begin
            cycles(1);
            gap++;
        end while (tick !== 1'b1 && gap < 2000);
    endtask
    task automatic wait_sleep(input logic want, input logic exp);
        int n;
        n = 0;
        #1;
        while (asleep !== want && n < 60) begin
            cycles(1);
            n++;
        end
        check(16'(asleep), 16'(exp));
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset_keep();
        wr_reg(ADDR_DIV_LOW, 8'h5a);
        wr_reg(ADDR_DIV_HIGH, 8'h01);
        wr_reg(ADDR_SCRATCH, 8'h3c);
        wr_reg(ADDR_LINE_CTRL, 8'h03);
        rst <= 1'b1;
        cycles(2);
        rst <= 1'b0;
        rd_reg(ADDR_DIV_LOW, v);
        check(16'(v), 16'h5a);
        rd_reg(ADDR_DIV_HIGH, v);
        check(16'(v), 16'h01);
        rd_reg(ADDR_SCRATCH, v);
        check(16'(v), 16'h3c);
        // A write with the clock enable low must not land
        ce <= 1'b0;
        wr_reg(ADDR_SCRATCH, 8'h99);
        ce <= 1'b1;
        rd_reg(ADDR_SCRATCH, v);
        check(16'(v), 16'h3c);
        rd_reg(ADDR_LINE_CTRL, v);
        check(16'(v), 16'(LINE_CTRL_RESET));
        rd_reg(ADDR_MODEM_CTRL, v);
        check(16'(v), 16'h80);
        check(16'(iid), 16'(IID_NONE));
    endtask
    task automatic t_baud();
        wr_reg(ADDR_DIV_LOW, 8'h06);
        wr_reg(ADDR_DIV_HIGH, 8'h00);
        tick_gap();
        check(16'(gap), 16'd24);
        wr_reg(ADDR_MODEM_CTRL, 8'h00);
        tick_gap();
        check(16'(gap), 16'd6);
        pin <= 1'b1;
        cycles(4);
        tick_gap();
        check(16'(gap), 16'd24);
        pin <= 1'b0;
        wr_reg(ADDR_DIV_HIGH, 8'h01);
        wr_reg(ADDR_DIV_LOW, 8'h00);
        tick_gap();
        check(16'(gap), 16'd256);
        wr_reg(ADDR_DIV_HIGH, 8'h00);
        wr_reg(ADDR_DIV_LOW, 8'h01);
        tick_gap();
        check(16'(gap), 16'd1);
        wr_reg(ADDR_DIV_LOW, 8'h00);
        tick_gap();
        check(16'(gap), 16'd2000);
        rd_reg(ADDR_LINE_CTRL, v);
        check(16'(v), 16'(LINE_CTRL_RESET));
    endtask
    task automatic t_break_trig();
        tx_ser <= 1'b0;
        cycles(2);
        check(16'(tx), 16'h0);
        tx_ser <= 1'b1;
        wr_reg(ADDR_LINE_CTRL, 8'h5d);
        cycles(2);
        check(16'(tx), 16'h0);
        wr_reg(ADDR_LINE_CTRL, 8'h1d);
        cycles(2);
        check(16'(tx), 16'h1);
        wr_reg(ADDR_FIFO_CTRL, 8'hb8);
        cycles(1);
        check(16'(rtrig), 16'h2);
        for (int i = 0; i < 4; i++) begin
            wr_reg(ADDR_FIFO_CTRL, {2'b01, 2'(i), 4'h8});
            tx_free <= 7'(need[i] - 1);
            cycles(2);
            check(16'(ttrig), 16'(i));
            check(16'(go), 16'h0);
            tx_free <= 7'(need[i]);
            cycles(2);
            check(16'(go), 16'h1);
        end
    endtask
    task automatic t_sleep();
        wr_reg(ADDR_DIV_LOW, 8'h06);
        wr_reg(ADDR_ENH_FEAT, 8'h10);
        wait_sleep(1'b1, 1'b0);
        rx_ne <= 1'b1;
        wr_reg(ADDR_INT_ENABLE, 8'h10);
        wait_sleep(1'b1, 1'b0);
        rx_ne <= 1'b0;
        tsr_empty <= 1'b0;
        wait_sleep(1'b1, 1'b0);
        tsr_empty <= 1'b1;
        oirq <= 1'b1;
        wait_sleep(1'b1, 1'b0);
        oirq <= 1'b0;
        wait_sleep(1'b1, 1'b1);
        tick_gap();
        check(16'(gap), 16'd2000);
        modem <= 4'h1;
        wait_sleep(1'b0, 1'b0);
        wait_sleep(1'b1, 1'b1);
        wr_reg(ADDR_RX_TX, 8'h55);
        wait_sleep(1'b0, 1'b0);
        wait_sleep(1'b1, 1'b1);
        send <= 1'b1;
        cycles(1);
        send <= 1'b0;
        wait_sleep(1'b0, 1'b0);
        cycles(100);
        // Sleep enable drops before any divisor write
        wr_reg(ADDR_INT_ENABLE, 8'h00);
        wait_sleep(1'b0, 1'b0);
    endtask
    task automatic t_timeout();
        wr_reg(ADDR_DIV_LOW, 8'h01);
        wr_reg(ADDR_LINE_CTRL, 8'h1c);
        rx_ne <= 1'b1;
        cycles(TO_TICKS - 24);
        check(16'(tout), 16'h0);
        repeat (60) if (tout !== 1'b1) cycles(1);
        check(16'(tout), 16'h1);
        check(16'(iid), 16'(IID_TIMEOUT));
        // Status shows the sticky flag and no sleep
        rd_reg(ADDR_STATUS, v);
        check(16'(v[2:1]), 16'h2);
        // Receive read strobe is seen in its own cycle, then the flag is gone
        @(posedge sys_clk);
        addr <= ADDR_RX_TX;
        rd <= 1'b1;
        #1;
        check(16'(rx_read), 16'h1);
        @(posedge sys_clk);
        rd <= 1'b0;
        #1;
        check(16'(tout), 16'h0);
        check(16'(iid), 16'(IID_NONE));
        rx_ne <= 1'b0;
    endtask

    // ************************************************************
    // Run control
    // ************************************************************
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset_keep();
        t_baud();
        t_break_trig();
        t_sleep();
        t_timeout();
        wrap_up();
    end
    // Whole run needs well under 20000 cycles
    initial begin
        #200000;
        num_errors++;
        wrap_up();
    end
endmodule // uart_baud_sleep_timeout_bench
